// >>> src/flash_self_program_ctrl.sv
`timescale 1ns/1ns
module flash_self_program_ctrl import flash_prog_pkg::*; #(
	parameter int PROG_CYCLES = PROG_MIN_CYC,
	parameter int PAGE_WORDS  = 32
) (
	// Clock and power-on reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// System reset request, one-cycle pulse
	input  wire logic         sysResetReq,
	// Register port
	input  wire logic [7:0]   regAddr,
	input  wire logic [7:0]   regWdata,
	input  wire logic         regWr,
	input  wire logic         regRd,
	output logic      [7:0]   regRdata,
	// Core instruction side
	input  wire logic         storeProgReq,
	input  wire logic         loadProgReq,
	input  wire logic [15:0]  addrPtr,
	input  wire logic [7:0]   dataLowIn,
	input  wire logic [7:0]   dataHighIn,
	output logic              readbackValid,
	output logic      [7:0]   readbackData,
	// EEPROM and fuses
	input  wire logic         eepromWriteBusy,
	input  wire logic [7:0]   fuseLowIn,
	input  wire logic [7:0]   fuseHighIn,
	// Flash array side
	output logic              flashOpActive,
	output logic      [1:0]   flashOpKind,
	output logic      [6:0]   flashPage,
	output logic              flashOpDone,
	input  wire logic [4:0]   bufRdIdx,
	output logic      [15:0]  bufRdData,
	// Section control and interrupt
	output logic              rwwReadBlock,
	output logic              cpuHalt,
	output logic              progReadyIrq,
	output logic      [5:0]   lockBits
);

	typedef struct packed {
		logic               intEn;
		logic               rwwBusy;
		logic [4:0]         cmd;
		logic               armed;
		logic [2:0]         age;
		op_state_type       opState;
		logic [6:0]         page;
		logic               halt;
		logic [TIMER_W-1:0] timer;
		logic [3:0]         lockData;
		logic [5:0]         lockBits;
		logic               loadActive;
		logic [7:0]         rdData;
		logic               rbValid;
		logic [7:0]         rbData;
		logic               done;
	} ctrl_state_type;

	ctrl_state_type st_r;
	ctrl_state_type st_nxt;

	logic       ctrlWr;
	logic       acceptCmd;
	logic       storeOk;
	logic       goLoad;
	logic       goErase;
	logic       goWrite;
	logic       goLock;
	logic       goReen;
	logic       rbGo;
	logic       opDone;
	logic       bufClear;
	logic       bufWrEn;
	logic [4:0] ctrlLow;
	logic [6:0] ptrPage;

	if (PROG_CYCLES < 1 || PROG_CYCLES >= 2 ** TIMER_W || PAGE_WORDS != 32) begin : g_bad
		$error("flash_self_program_ctrl: unsupported parameter");
	end

	////////////////////////////////////////////////////////////////
	// Command pattern check
	function automatic logic isCmd(input logic [4:0] c);
		isCmd = (c == CMD_LOAD) || (c == CMD_ERASE) || (c == CMD_WRITE) ||
			(c == CMD_LOCK) || (c == CMD_REEN);
	endfunction

	////////////////////////////////////////////////////////////////
	// Request decode
	always_comb begin
		ctrlLow   = regWdata[4:0];
		ptrPage   = addrPtr[PAGE_LSB +: PAGE_W];
		ctrlWr    = regWr && (regAddr == CTRL_OFS);
		storeOk   = st_r.armed && storeProgReq && !eepromWriteBusy;
		goLoad    = storeOk && (st_r.cmd == CMD_LOAD);
		goErase   = storeOk && (st_r.cmd == CMD_ERASE);
		goWrite   = storeOk && (st_r.cmd == CMD_WRITE);
		goLock    = storeOk && (st_r.cmd == CMD_LOCK);
		goReen    = storeOk && (st_r.cmd == CMD_REEN);
		// Odd patterns, busy or starting engine, or EEPROM write leave the command bits alone
		acceptCmd = ctrlWr && isCmd(ctrlLow) && (st_r.opState == ST_IDLE) &&
			!goErase && !goWrite && !goLock && !eepromWriteBusy;
		// Readback only inside the shorter load window
		rbGo      = st_r.armed && loadProgReq && (st_r.cmd == CMD_LOCK) &&
			(st_r.age <= LPM_WIN) && !eepromWriteBusy;
		opDone    = (st_r.opState != ST_IDLE) && (st_r.timer == TIMER_W'(1));
		bufWrEn   = goLoad;
		bufClear  = sysResetReq ||
			(opDone && (st_r.opState == ST_WRITE)) ||
			(acceptCmd && (ctrlLow == CMD_REEN)) ||
			(eepromWriteBusy && st_r.loadActive);
	end

	////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_nxt         = st_r;
		st_nxt.rbValid = 1'b0;
		st_nxt.done    = 1'b0;

		// Register read data, one cycle late
		st_nxt.rdData = 8'h00;
		if (regRd) begin
			case (regAddr)
				CTRL_OFS: st_nxt.rdData = {st_r.intEn, st_r.rwwBusy, 1'b0, st_r.cmd};
				STAT_OFS: st_nxt.rdData = {3'h0, eepromWriteBusy, st_r.loadActive,
					st_r.halt, st_r.opState};
				default:  st_nxt.rdData = 8'h00;
			endcase
		end

		// Instruction window
		if (st_r.armed) begin
			if (goLoad || goErase || goWrite || goLock || goReen || rbGo) begin
				st_nxt.armed = 1'b0;
			end else if (st_r.age == STORE_WIN) begin
				st_nxt.armed = 1'b0;
				st_nxt.cmd   = 5'h00;
			end else begin
				st_nxt.age = st_r.age + 3'h1;
			end
		end

		// Word load into the page buffer
		if (goLoad) begin
			st_nxt.cmd        = 5'h00;
			st_nxt.rwwBusy    = 1'b0;
			st_nxt.loadActive = 1'b1;
		end

		// Erase or write start, page latched here
		if (goErase || goWrite) begin
			st_nxt.opState = goErase ? ST_ERASE : ST_WRITE;
			st_nxt.page    = ptrPage;
			st_nxt.timer   = TIMER_W'(PROG_CYCLES);
			if (ptrPage < RWW_PAGES) begin
				st_nxt.rwwBusy = 1'b1;
			end else begin
				st_nxt.halt = 1'b1;
			end
		end

		// Lock programming start; pointer ignored, nothing blocked
		if (goLock) begin
			st_nxt.opState  = ST_LOCK;
			st_nxt.lockData = dataLowIn[LOCK_LSB +: 4];
			st_nxt.timer    = TIMER_W'(PROG_CYCLES);
		end

		// Re-enable instruction only closes the window
		if (goReen) begin
			st_nxt.cmd = 5'h00;
		end

		// Fuse and lock readback
		if (rbGo) begin
			st_nxt.cmd     = 5'h00;
			st_nxt.rbValid = 1'b1;
			case (addrPtr)
				RB_FUSE_LO: st_nxt.rbData = fuseLowIn;
				RB_LOCK:    st_nxt.rbData = {2'b11, st_r.lockBits};
				RB_FUSE_HI: st_nxt.rbData = fuseHighIn;
				default:    st_nxt.rbData = 8'hff;
			endcase
		end

		// Running operation; enable bit holds until the end
		if (st_r.opState != ST_IDLE) begin
			if (opDone) begin
				st_nxt.opState = ST_IDLE;
				st_nxt.cmd     = 5'h00;
				st_nxt.halt    = 1'b0;
				st_nxt.done    = 1'b1;
				if (st_r.opState == ST_LOCK) begin
					st_nxt.lockBits[LOCK_LSB +: 4] = st_r.lockBits[LOCK_LSB +: 4] &
						st_r.lockData;
				end
				if (st_r.opState == ST_WRITE) begin
					st_nxt.loadActive = 1'b0;
				end
			end else begin
				st_nxt.timer = st_r.timer - TIMER_W'(1);
			end
		end

		// Control register write
		if (ctrlWr) begin
			st_nxt.intEn = regWdata[INT_EN_BIT];
		end
		if (acceptCmd) begin
			st_nxt.cmd   = ctrlLow;
			st_nxt.armed = 1'b1;
			st_nxt.age   = 3'h1;
			if (ctrlLow == CMD_REEN) begin
				st_nxt.rwwBusy    = 1'b0;
				st_nxt.loadActive = 1'b0;
			end
		end

		// EEPROM write aborts a load sequence
		if (eepromWriteBusy && st_r.loadActive) begin
			st_nxt.loadActive = 1'b0;
		end

		// System reset leaves a running operation to finish
		if (sysResetReq) begin
			st_nxt.intEn      = 1'b0;
			st_nxt.armed      = 1'b0;
			st_nxt.loadActive = 1'b0;
			// An operation starting this cycle keeps its command bits too
			if (st_nxt.opState == ST_IDLE) begin
				st_nxt.cmd = 5'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// State register; only power-on reset stops the engine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r          <= '0;
			st_r.intEn    <= CTRL_RST[INT_EN_BIT];
			st_r.rwwBusy  <= CTRL_RST[BUSY_BIT];
			st_r.opState  <= ST_IDLE;
			st_r.lockBits <= LOCK_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Page buffer
	page_word_buffer #(
		.WORDS (PAGE_WORDS),
		.WIDTH (16)
	) u_buf (
		.clk    (clk),
		.rst_n  (rst_n),
		.clear  (bufClear),
		.wrEn   (bufWrEn),
		.wrIdx  (addrPtr[WORD_LSB +: WORD_W]),
		.wrData ({dataHighIn, dataLowIn}),
		.rdIdx  (bufRdIdx),
		.rdData (bufRdData)
	);

	////////////////////////////////////////////////////////////////
	// Outputs
	assign regRdata      = st_r.rdData;
	assign readbackValid = st_r.rbValid;
	assign readbackData  = st_r.rbData;
	assign flashOpActive = (st_r.opState != ST_IDLE);
	assign flashOpKind   = st_r.opState;
	assign flashPage     = st_r.page;
	assign flashOpDone   = st_r.done;
	assign rwwReadBlock  = st_r.rwwBusy;
	assign cpuHalt       = st_r.halt;
	assign progReadyIrq  = st_r.intEn && !st_r.cmd[0];
	assign lockBits      = st_r.lockBits;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_quiet;
		!storeProgReq && !loadProgReq && !regWr && !sysResetReq;
	endsequence

	sequence s_armIdle;
		acceptCmd ##1 s_quiet [*4];
	endsequence

	a_irq_level: assert property (
		st_r.intEn && !flashOpActive && !st_r.armed |-> progReadyIrq
	) else $error("ready interrupt not asserted");

	a_window_expiry: assert property (
		s_armIdle |=> !st_r.cmd[0] && !st_r.armed
	) else $error("command bits did not self-clear");

	a_rww_busy: assert property (
		flashOpActive && (flashOpKind != ST_LOCK) && (flashPage < RWW_PAGES) |-> rwwReadBlock && !cpuHalt
	) else $error("concurrent section not blocked");

	a_no_concurrent_section_halt: assert property (
		(goErase || goWrite) && (ptrPage >= RWW_PAGES) |=> cpuHalt && $stable(rwwReadBlock)
	) else $error("cpu not halted");

	a_lock_open: assert property (
		flashOpActive && (flashOpKind == ST_LOCK) |-> !cpuHalt && $stable(rwwReadBlock)
	) else $error("lock programming blocked reads");

	a_op_length: assert property (
		$rose(flashOpActive) |-> st_r.timer == TIMER_W'(PROG_CYCLES)
	) else $error("operation timer not loaded");

	a_op_end: assert property (
		flashOpActive && st_r.timer == TIMER_W'(1) |=> !flashOpActive && flashOpDone
	) else $error("operation did not end on time");

	a_enable_hold: assert property (
		flashOpActive |-> st_r.cmd[0]
	) else $error("enable bit dropped early");

	a_eeprom_block: assert property (
		eepromWriteBusy |=> !$rose(flashOpActive) && !readbackValid
	) else $error("command taken during eeprom write");

	a_fuse_low: assert property (
		rbGo && addrPtr == RB_FUSE_LO |=> readbackValid && readbackData == $past(fuseLowIn)
	) else $error("wrong low fuse readback");

	a_write_clear: assert property (
		opDone && st_r.opState == ST_WRITE |-> ##2 bufRdData == BUF_ERASED
	) else $error("buffer not cleared after write");

endmodule

// >>> common/flash_prog_pkg.sv
package flash_prog_pkg;

	// Register offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h01;

	// Control register bit positions
	localparam int INT_EN_BIT = 7;
	localparam int BUSY_BIT   = 6;

	// Control register reset value
	localparam logic [7:0] CTRL_RST = 8'h00;

	// Command codes in the low five control bits
	localparam logic [4:0] CMD_LOAD  = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_LOCK  = 5'h09;
	localparam logic [4:0] CMD_REEN  = 5'h11;

	// Instruction windows after the control write, in clocks
	localparam logic [2:0] STORE_WIN = 3'h4;
	localparam logic [2:0] LPM_WIN   = 3'h3;

	// Pointer fields
	localparam int WORD_LSB = 1;
	localparam int WORD_W   = 5;
	localparam int PAGE_LSB = 6;
	localparam int PAGE_W   = 7;
	localparam int LOCK_LSB = 2;

	// Readback addresses
	localparam logic [15:0] RB_FUSE_LO = 16'h0000;
	localparam logic [15:0] RB_LOCK    = 16'h0001;
	localparam logic [15:0] RB_FUSE_HI = 16'h0003;

	// First page of the no-concurrent section
	localparam logic [6:0] RWW_PAGES = 7'h60;

	// Reset values of storage
	localparam logic [5:0]  LOCK_RST   = 6'h3f;
	localparam logic [15:0] BUF_ERASED = 16'hffff;

	// Programming time
	localparam int CLK_PERIOD_NS = 50;
	localparam int PROG_MIN_NS   = 3700000;
	localparam int PROG_MAX_NS   = 4500000;
	localparam int PROG_MIN_CYC  = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_MAX_CYC  = PROG_MAX_NS / CLK_PERIOD_NS;
	localparam int TIMER_W       = 20;

	// Running flash operation
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ERASE = 2'b01,
		ST_WRITE = 2'b10,
		ST_LOCK  = 2'b11
	} op_state_type;

endpackage

// >>> src/page_word_buffer.sv
`timescale 1ns/1ns
module page_word_buffer import flash_prog_pkg::*; #(
	parameter int WORDS = 32,
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// Clear and write
	input  wire logic                     clear,
	input  wire logic                     wrEn,
	input  wire logic [$clog2(WORDS)-1:0] wrIdx,
	input  wire logic [WIDTH-1:0]         wrData,
	// Registered read
	input  wire logic [$clog2(WORDS)-1:0] rdIdx,
	output logic      [WIDTH-1:0]         rdData
);

	typedef struct packed {
		logic [WORDS-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0]            rd;
	} buf_state_type;

	buf_state_type st_r;
	buf_state_type st_nxt;

	if (WORDS < 2 || WIDTH != 16) begin : g_bad
		$error("page_word_buffer: unsupported size");
	end

	////////////////////////////////////////////////////////////////
	// Clear wins over a load in the same cycle
	always_comb begin
		st_nxt = st_r;
		st_nxt.rd = st_r.mem[rdIdx];
		if (clear) begin
			st_nxt.mem = {WORDS{BUF_ERASED}};
		end else if (wrEn) begin
			st_nxt.mem[wrIdx] = wrData;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= {(WORDS + 1){BUF_ERASED}};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdData = st_r.rd;

endmodule

// >>> verification/cpu_core_model.sv
`timescale 1ns/1ns
module cpu_core_model (
	// Clock and status
	input  wire logic        clk,
	input  wire logic        eepromWriteBusy,
	// Register port
	output logic      [7:0]  regAddr,
	output logic      [7:0]  regWdata,
	output logic             regWr,
	output logic             regRd,
	input  wire logic [7:0]  regRdata,
	// Instruction side
	output logic             storeProgReq,
	output logic             loadProgReq,
	output logic      [15:0] addrPtr,
	output logic      [7:0]  dataLowIn,
	output logic      [7:0]  dataHighIn
);
	// Idle core
	initial begin
		{regAddr, regWdata, regWr, regRd, storeProgReq, loadProgReq} = '0;
		{addrPtr, dataLowIn, dataHighIn} = '0;
	end
	////////////////////////////////////////////////////////////////
	// Control write, waits for EEPROM idle when ee is set
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit ee);
		for (int n = 0; n < 200 && ee && eepromWriteBusy !== 1'b0; n++) begin
			@(posedge clk);
		end
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
		regWdata <= ~d;
	endtask
	// Register read, data taken in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask
	// Store or load instruction d clocks after the control write
	task automatic instr(input bit ld, input int d, input logic [15:0] p, input logic [15:0] w);
		repeat (d - 1) @(posedge clk);
		addrPtr <= p;
		{dataHighIn, dataLowIn} <= w;
		if (ld)
			loadProgReq <= 1'b1;
		else
			storeProgReq <= 1'b1;
		@(posedge clk);
		{loadProgReq, storeProgReq} <= 2'b00;
		{dataHighIn, dataLowIn} <= ~w;
	endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ns
module tb import flash_prog_pkg::*; ;
	localparam int PC = 10;
	logic        clk = 0, rst_n, sysResetReq, eepromWriteBusy;
	logic [7:0]  regAddr, regWdata, regRdata, dataLowIn, dataHighIn, readbackData, fuseLowIn, fuseHighIn, v;
	logic        regWr, regRd, storeProgReq, loadProgReq, readbackValid, flashOpActive, flashOpDone;
	logic        rwwReadBlock, cpuHalt, progReadyIrq;
	logic [15:0] addrPtr, bufRdData;
	logic [15:0] bufExp [32];
	logic [1:0]  flashOpKind;
	logic [6:0]  flashPage, pageExp;
	logic [4:0]  bufRdIdx, idx;
	logic [5:0]  lockBits, lockExp;
	int          err_count = 0, checks_done = 0;
	// Clock and parts
	always #25 clk = ~clk;
	cpu_core_model core (.clk(clk), .eepromWriteBusy(eepromWriteBusy), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .storeProgReq(storeProgReq), .loadProgReq(loadProgReq),
		.addrPtr(addrPtr), .dataLowIn(dataLowIn), .dataHighIn(dataHighIn));
	flash_self_program_ctrl #(.PROG_CYCLES(PC), .PAGE_WORDS(32)) dut (.clk(clk), .rst_n(rst_n),
		.sysResetReq(sysResetReq), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .storeProgReq(storeProgReq), .loadProgReq(loadProgReq), .addrPtr(addrPtr),
		.dataLowIn(dataLowIn), .dataHighIn(dataHighIn), .readbackValid(readbackValid),
		.readbackData(readbackData), .eepromWriteBusy(eepromWriteBusy), .fuseLowIn(fuseLowIn),
		.fuseHighIn(fuseHighIn), .flashOpActive(flashOpActive), .flashOpKind(flashOpKind), .flashPage(flashPage),
		.flashOpDone(flashOpDone), .bufRdIdx(bufRdIdx), .bufRdData(bufRdData), .rwwReadBlock(rwwReadBlock),
		.cpuHalt(cpuHalt), .progReadyIrq(progReadyIrq), .lockBits(lockBits));
	////////////////////////////////////////////////////////////////
	// Compares and expectations
	task automatic chkVal(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkBit(input string n, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask
	function automatic logic [7:0] rbExp(input logic [15:0] p);
		return p == RB_LOCK ? {2'b11, lockExp} : p == RB_FUSE_LO ? fuseLowIn : p == RB_FUSE_HI ? fuseHighIn : 8'hff;
	endfunction
	task automatic tally_and_finish;
		if (err_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Buffer contents against the expected image
	task automatic bufChk;
		for (int i = 0; i < 32; i++) begin
			bufRdIdx <= 5'(i);
			@(posedge clk);
			#1 chkVal("buffer word", bufExp[i], bufRdData);
		end
	endtask
	task automatic load(input logic [4:0] i, input logic [15:0] w);
		core.wr(CTRL_OFS, {3'b000, CMD_LOAD}, 1);
		core.instr(0, 1 + $urandom % 4, {3'b000, 7'($urandom), i, 1'b0}, w);
		bufExp[i] = w;
	endtask
	task automatic ctrlIdle;
		core.rd(CTRL_OFS, v);
		chkVal("command bits", 8'h00, {3'b000, v[4:0]});
	endtask
	// One timed operation, page word bits zero, optional system reset
	task automatic opRun(input logic [4:0] c, input logic [6:0] p, input logic [7:0] lo, input op_state_type k,
		input bit sr);
		int n;
		bit blk;
		n = 0;
		blk = (k != ST_LOCK) && (p < RWW_PAGES);
		if (k != ST_LOCK)
			pageExp = p; // Lock ignores the pointer
		core.wr(CTRL_OFS, {3'b100, c}, 1);
		core.instr(0, 1 + $urandom % 4, {3'b000, p, 6'h00}, {8'h5a, lo});
		core.addrPtr <= 16'hffff;
		// First active cycle follows the store edge
		#1 n = int'(flashOpActive === 1'b1);
		for (int i = 0; i < 60 && flashOpDone !== 1'b1; i++) begin
			@(posedge clk);
			sysResetReq <= sr && n == 3;
			#1 n += flashOpActive === 1'b1;
			if (n == 2 && i < 3) begin
				chkVal("op kind", 16'(k), 16'(flashOpKind));
				chkVal("op page", 16'(pageExp), 16'(flashPage));
				chkBit("rww block", blk, rwwReadBlock);
				chkBit("cpu halt", k != ST_LOCK && !blk, cpuHalt);
				chkBit("ready irq", 1'b0, progReadyIrq);
			end
		end
		chkVal("op cycles", 16'(PC), 16'(n));
		#50 chkBit("ready irq", !sr, progReadyIrq);
		chkBit("cpu halt", 1'b0, cpuHalt);
		chkBit("rww block", blk, rwwReadBlock);
		if (k == ST_WRITE || sr)
			bufExp = '{default: BUF_ERASED};
		if (k == ST_LOCK)
			lockExp = lockExp & {lo[5:2], 2'b11};
		chkVal("lock bits", 16'(lockExp), 16'(lockBits));
		bufChk;
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst_n, sysResetReq, eepromWriteBusy, bufRdIdx} = '0;
		void'($urandom(60));
		fuseLowIn = 8'($urandom);
		fuseHighIn = 8'($urandom);
		bufExp = '{default: BUF_ERASED};
		lockExp = LOCK_RST;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		ctrlIdle;
		chkVal("lock bits", 16'(LOCK_RST), 16'(lockBits));
		for (int k = 0; k < 4; k++)
			load(5'(k * 8 + $urandom % 8), 16'($urandom));
		ctrlIdle;
		bufChk;
		core.rd(STAT_OFS, v);
		chkVal("status", 16'h0008, 16'(v));
		opRun(CMD_WRITE, 7'($urandom % 96), 8'h00, ST_WRITE, 0);
		core.wr(CTRL_OFS, {3'b000, CMD_REEN}, 1);
		@(posedge clk);
		#1 chkBit("rww block", 1'b0, rwwReadBlock);
		load(5'h1f, 16'h1234);
		core.wr(CTRL_OFS, {3'b000, CMD_REEN}, 1);
		@(posedge clk);
		#1 chkBit("rww block", 1'b0, rwwReadBlock);
		bufExp = '{default: BUF_ERASED};
		bufChk;
		opRun(CMD_ERASE, 7'(96 + $urandom % 32), 8'h00, ST_ERASE, 0);
		load(5'h03, 16'h0f0f);
		opRun(CMD_WRITE, 7'(96 + $urandom % 32), 8'h00, ST_WRITE, 1);
		opRun(CMD_LOCK, 7'h00, 8'($urandom) | 8'hc3, ST_LOCK, 0);
		foreach (bufExp[i]) begin
			if (i < 4) begin
				core.wr(CTRL_OFS, {3'b000, CMD_LOCK}, 1);
				core.instr(1, 1 + $urandom % 3, 16'(i), 16'h0000);
				#1 chkBit("readback valid", 1'b1, readbackValid);
				chkVal("readback", 16'(rbExp(16'(i))), 16'(readbackData));
				ctrlIdle;
			end
		end
		core.wr(CTRL_OFS, {3'b000, CMD_WRITE}, 1);
		repeat (5) @(posedge clk);
		ctrlIdle;
		core.instr(0, 1, 16'h0040, 16'h0000);
		#60 chkBit("op active", 1'b0, flashOpActive);
		foreach (bufExp[i])
			if (i < 4) begin
				core.wr(CTRL_OFS, 8'({3'b000, i[1:0], 3'b111} ^ 8'h18), 1);
				ctrlIdle;
			end
		eepromWriteBusy <= 1'b1;
		core.wr(CTRL_OFS, {3'b000, CMD_LOCK}, 0);
		ctrlIdle;
		eepromWriteBusy <= 1'b0;
		load(5'h07, 16'h00ff);
		eepromWriteBusy <= 1'b1;
		repeat (3) @(posedge clk);
		eepromWriteBusy <= 1'b0;
		bufExp = '{default: BUF_ERASED};
		bufChk;
		load(5'h09, 16'habcd);
		sysResetReq <= 1'b1;
		@(posedge clk);
		sysResetReq <= 1'b0;
		bufExp = '{default: BUF_ERASED};
		bufChk;
		tally_and_finish;
	end
	// Watchdog
	initial begin
		#200000;
		err_count++;
		tally_and_finish;
	end
endmodule
